// *** vbe_defines.vh ***
/*
 * constants for the video memory blit engine: command block layout,
 * field positions, modes, wishbone register offsets and reset values.
 * assumes inclusion by bare name from the engine source.
 */
`ifndef VBE_DEFINES_VH
`define VBE_DEFINES_VH

// ----------------------------------------------------------------------
// command block
// ----------------------------------------------------------------------
`define VBE_BLK_LEN 5'h15
`define VBE_B_SRC0 5'h00
`define VBE_B_SRC1 5'h01
`define VBE_B_SRC2 5'h02
`define VBE_B_SSY0 5'h03
`define VBE_B_SSY1 5'h04
`define VBE_B_SSX 5'h05
`define VBE_B_DST0 5'h06
`define VBE_B_DST1 5'h07
`define VBE_B_DST2 5'h08
`define VBE_B_DSY0 5'h09
`define VBE_B_DSY1 5'h0a
`define VBE_B_DSX 5'h0b
`define VBE_B_WID0 5'h0c
`define VBE_B_WID1 5'h0d
`define VBE_B_HGT 5'h0e
`define VBE_B_AND 5'h0f
`define VBE_B_XOR 5'h10
`define VBE_B_COL 5'h11
`define VBE_B_ZOOM 5'h12
`define VBE_B_PAT 5'h13
`define VBE_B_CTL 5'h14

// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define VBE_PAT_EN 7
`define VBE_PAT_LEN_MSB 5
`define VBE_CTL_CHAIN 3
`define VBE_CTL_MODE_MSB 2
`define VBE_HZ_MSB 2
`define VBE_VZ_LSB 4
`define VBE_VZ_MSB 6
`define VBE_SEG_SHIFT 5

// ----------------------------------------------------------------------
// modes
// ----------------------------------------------------------------------
`define VBE_MODE_COPY 3'h0
`define VBE_MODE_SET 3'h1
`define VBE_MODE_ADD 3'h2
`define VBE_MODE_OR 3'h3
`define VBE_MODE_AND 3'h4
`define VBE_MODE_XOR 3'h5
`define VBE_MODE_NIB 3'h6
`define VBE_MODE_RSVD 3'h7

// ----------------------------------------------------------------------
// wishbone registers (word offsets as byte addresses)
// ----------------------------------------------------------------------
`define VBE_REG_LIST_LO 4'h0
`define VBE_REG_LIST_HI 4'h4
`define VBE_REG_CTRL 4'h8
`define VBE_REG_STAT 4'hc
`define VBE_CTRL_START 0
`define VBE_CTRL_STOP 1
`define VBE_ADDR_RST 19'h00000

`endif

// *** vbe_blit_engine.v ***
/*
 * video memory blit engine: fetches command blocks from video memory,
 * copies, transforms, scales and combines bytes, checks collisions.
 * assumes a byte-wide video memory port with a request/ack handshake
 * and a classic wishbone slave port for software control.
 */
// Overview of operation
// - list of blocks in memory; a block with chain clear ends the list
// - each block is fetched as 21 consecutive bytes in fixed order
// - source base is 19 bits little endian, third byte gives bits 16-18
// - after each line add signed 12-bit source line step
// - source per-byte step is a signed 8-bit value
// - destination base is 19 bits little endian, third byte bits 16-18
// - after each line add signed 12-bit destination line step
// - destination per-byte step is a signed 8-bit value
// - width field plus one gives 1 to 512 bytes per line
// - height field plus one gives 1 to 256 lines
// - each source byte is ANDed with the and mask first
// - then XORed with the xor mask giving the final source value
// - collisions only checked in modes 1 to 6, never in mode 0
// - byte modes: mask bit n covers 32n..32n+31, bit 0 excludes zero
// - nibble mode: bit n covers 2n and 2n+1, bit 0 only value 1
// - collisions use destination byte read before the write
// - horizontal and vertical zoom factors are field plus one
// - zoom replicates destination only; source walk unchanged
// - pattern disabled means source never rewinds inside a line
// - pattern enabled rewinds source every pattern length plus one bytes
// - line width wins; a line may end mid pattern
// - mode 0 writes every byte, no transparency, no collision
// - collision stores destination value; zero mask skips read in mode 1
// - chain clear ends and clears busy, else next block is loaded
`timescale 1ns/1ps
`default_nettype none
`include "vbe_defines.vh"

module vbe_blit_engine #(
  parameter AW = 19
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // video memory port
  output reg [AW-1:0] memAddr,
  output reg memReq,
  output reg memWe,
  output reg [7:0] memWdata,
  input wire memAck,
  input wire [7:0] memRdata,
  // status
  output wire busy
);

  // --------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_FETCH = 4'h1;
  localparam [3:0] ST_SRC = 4'h2;
  localparam [3:0] ST_DRD = 4'h3;
  localparam [3:0] ST_DWR = 4'h4;
  localparam [3:0] ST_BYTE = 4'h5;
  localparam [3:0] ST_LINE = 4'h6;
  localparam [3:0] ST_END = 4'h7;

  reg [3:0] state_q;
  reg [AW-1:0] listPtr_q;
  reg [4:0] fetchIdx_q;
  reg [7:0] blk_q [0:`VBE_BLK_LEN-1];
  reg [AW-1:0] srcLine_q, srcPtr_q, dstLine_q, dstPtr_q, patBase_q;
  reg [8:0] xCnt_q;
  reg [7:0] yCnt_q;
  reg [2:0] hzCnt_q, vzCnt_q;
  reg [5:0] patCnt_q;
  reg [7:0] srcVal_q, dstVal_q;
  reg [7:0] colCode_q;
  reg colFlag_q;
  reg stopReq_q;

  // --------------------------------------------------------------------
  // block fields
  // --------------------------------------------------------------------
  wire [AW-1:0] srcBase = {blk_q[`VBE_B_SRC2][2:0], blk_q[`VBE_B_SRC1],
                           blk_q[`VBE_B_SRC0]};
  wire [AW-1:0] dstBase = {blk_q[`VBE_B_DST2][2:0], blk_q[`VBE_B_DST1],
                           blk_q[`VBE_B_DST0]};
  wire [11:0] srcStepY = {blk_q[`VBE_B_SSY1][3:0], blk_q[`VBE_B_SSY0]};
  wire [11:0] dstStepY = {blk_q[`VBE_B_DSY1][3:0], blk_q[`VBE_B_DSY0]};
  wire [7:0] srcStepX = blk_q[`VBE_B_SSX];
  wire [7:0] dstStepX = blk_q[`VBE_B_DSX];
  wire [8:0] width = {blk_q[`VBE_B_WID1][0], blk_q[`VBE_B_WID0]};
  wire [7:0] height = blk_q[`VBE_B_HGT];
  wire [7:0] colMask = blk_q[`VBE_B_COL];
  wire [2:0] hZoom = blk_q[`VBE_B_ZOOM][`VBE_HZ_MSB:0];
  wire [2:0] vZoom = blk_q[`VBE_B_ZOOM][`VBE_VZ_MSB:`VBE_VZ_LSB];
  wire patEn = blk_q[`VBE_B_PAT][`VBE_PAT_EN];
  wire [5:0] patLen = blk_q[`VBE_B_PAT][`VBE_PAT_LEN_MSB:0];
  wire [2:0] mode = blk_q[`VBE_B_CTL][`VBE_CTL_MODE_MSB:0];
  wire chain = blk_q[`VBE_B_CTL][`VBE_CTL_CHAIN];

  // sign extensions; sums wrap within the address space
  wire [AW-1:0] sxStep = {{(AW-8){srcStepX[7]}}, srcStepX};
  wire [AW-1:0] dxStep = {{(AW-8){dstStepX[7]}}, dstStepX};
  wire [AW-1:0] syStep = {{(AW-12){srcStepY[11]}}, srcStepY};
  wire [AW-1:0] dyStep = {{(AW-12){dstStepY[11]}}, dstStepY};

  // transformed source byte
  wire [7:0] srcX = (memRdata & blk_q[`VBE_B_AND])
                    ^ blk_q[`VBE_B_XOR];

  // --------------------------------------------------------------------
  // collision decode
  // --------------------------------------------------------------------
  function segHit;
    input [7:0] d;
    input [7:0] m;
    begin
      segHit = m[d[7:`VBE_SEG_SHIFT]] && (d != 8'h00);
    end
  endfunction

  function nibHit;
    input [3:0] d;
    input [7:0] m;
    begin
      nibHit = m[d[3:1]] && (d != 4'h0);
    end
  endfunction

  wire modeNib = (mode == `VBE_MODE_NIB);
  wire srcZero = (srcVal_q == 8'h00);
  wire loHit = nibHit(memRdata[3:0], colMask) && (srcVal_q[3:0] != 4'h0);
  wire hiHit = nibHit(memRdata[7:4], colMask) && (srcVal_q[7:4] != 4'h0);
  // dest value comes straight from the read, before any write
  wire byteHit = segHit(memRdata, colMask) && !srcZero;

  reg [7:0] combined;
  always @* begin
    case (mode)
      `VBE_MODE_ADD: combined = dstVal_q + srcVal_q;
      `VBE_MODE_OR: combined = dstVal_q | srcVal_q;
      `VBE_MODE_AND: combined = dstVal_q & srcVal_q;
      `VBE_MODE_XOR: combined = dstVal_q ^ srcVal_q;
      `VBE_MODE_NIB: combined = {(srcVal_q[7:4] != 4'h0) ? srcVal_q[7:4] : dstVal_q[7:4],
                                 (srcVal_q[3:0] != 4'h0) ? srcVal_q[3:0] : dstVal_q[3:0]};
      default: combined = srcVal_q;
    endcase
  end

  // --------------------------------------------------------------------
  // wishbone slave
  // --------------------------------------------------------------------
  wire wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wbWr = wbHit && wb_we_i;
  wire startCmd = wbWr && (wb_adr_i == `VBE_REG_CTRL) && wb_sel_i[0]
                  && wb_dat_i[`VBE_CTRL_START];
  wire stopCmd = wbWr && (wb_adr_i == `VBE_REG_CTRL) && wb_sel_i[0]
                 && wb_dat_i[`VBE_CTRL_STOP];

  assign busy = (state_q != ST_IDLE);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wbHit;
      if (wbHit && !wb_we_i) begin
        case (wb_adr_i)
          `VBE_REG_LIST_LO: wb_dat_o <= {16'h0000, listPtr_q[15:0]};
          `VBE_REG_LIST_HI: wb_dat_o <= {29'h00000000, listPtr_q[AW-1:16]};
          `VBE_REG_STAT: wb_dat_o <= {22'h000000, colFlag_q, busy, colCode_q};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // engine
  // --------------------------------------------------------------------
  integer i;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      listPtr_q <= `VBE_ADDR_RST;
      fetchIdx_q <= 5'h00;
      for (i = 0; i < `VBE_BLK_LEN; i = i + 1) begin
        blk_q[i] <= 8'h00;
      end
      srcLine_q <= `VBE_ADDR_RST;
      srcPtr_q <= `VBE_ADDR_RST;
      dstLine_q <= `VBE_ADDR_RST;
      dstPtr_q <= `VBE_ADDR_RST;
      patBase_q <= `VBE_ADDR_RST;
      xCnt_q <= 9'h000;
      yCnt_q <= 8'h00;
      hzCnt_q <= 3'h0;
      vzCnt_q <= 3'h0;
      patCnt_q <= 6'h00;
      srcVal_q <= 8'h00;
      dstVal_q <= 8'h00;
      colCode_q <= 8'h00;
      colFlag_q <= 1'b0;
      stopReq_q <= 1'b0;
      memAddr <= `VBE_ADDR_RST;
      memReq <= 1'b0;
      memWe <= 1'b0;
      memWdata <= 8'h00;
    end else begin
      if (wbWr && wb_adr_i == `VBE_REG_LIST_LO && !busy) begin
        if (wb_sel_i[0]) listPtr_q[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) listPtr_q[15:8] <= wb_dat_i[15:8];
      end
      if (wbWr && wb_adr_i == `VBE_REG_LIST_HI && !busy && wb_sel_i[0]) begin
        listPtr_q[AW-1:16] <= wb_dat_i[2:0];
      end
      if (stopCmd && busy) begin
        stopReq_q <= 1'b1;
      end
      // reading status clears the collision flag; a new hit wins below
      if (wbHit && !wb_we_i && wb_adr_i == `VBE_REG_STAT) begin
        colFlag_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          stopReq_q <= 1'b0;
          if (startCmd) begin
            fetchIdx_q <= 5'h00;
            memAddr <= listPtr_q;
            memWe <= 1'b0;
            memReq <= 1'b1;
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (memAck) begin
            blk_q[fetchIdx_q] <= memRdata;
            listPtr_q <= listPtr_q + 1'b1;
            memAddr <= listPtr_q + 1'b1;
            if (fetchIdx_q == `VBE_BLK_LEN - 5'h01) begin
              memReq <= 1'b0;
              state_q <= ST_LINE;
              xCnt_q <= 9'h000;
              yCnt_q <= 8'h00;
              vzCnt_q <= 3'h0;
              fetchIdx_q <= 5'h1f;
            end else begin
              fetchIdx_q <= fetchIdx_q + 5'h01;
            end
          end
        end
        ST_LINE: begin
          // first entry after fetch loads bases, later entries start a line
          if (fetchIdx_q == 5'h1f) begin
            fetchIdx_q <= 5'h00;
            srcLine_q <= srcBase;
            dstLine_q <= dstBase;
            srcPtr_q <= srcBase;
            dstPtr_q <= dstBase;
            patBase_q <= srcBase;
          end else begin
            srcPtr_q <= srcLine_q;
            dstPtr_q <= dstLine_q;
            patBase_q <= srcLine_q;
          end
          xCnt_q <= 9'h000;
          hzCnt_q <= 3'h0;
          patCnt_q <= 6'h00;
          state_q <= ST_SRC;
        end
        ST_SRC: begin
          if (!memReq) begin
            memAddr <= srcPtr_q;
            memWe <= 1'b0;
            memReq <= 1'b1;
          end else if (memAck) begin
            srcVal_q <= srcX;
            memAddr <= dstPtr_q;
            // copy, and mode 1 with no mask, skip the read
            if (mode == `VBE_MODE_COPY ||
                (mode == `VBE_MODE_SET && colMask == 8'h00)) begin
              memReq <= 1'b0;
              state_q <= (mode == `VBE_MODE_COPY || srcX != 8'h00) ? ST_DWR : ST_BYTE;
            end else if (srcX == 8'h00 && mode != `VBE_MODE_AND && mode != `VBE_MODE_RSVD) begin
              memReq <= 1'b0;
              state_q <= ST_BYTE;
            end else begin
              state_q <= ST_DRD;
            end
          end
        end
        ST_DRD: begin
          if (memAck) begin
            dstVal_q <= memRdata;
            memReq <= 1'b0;
            state_q <= ST_DWR;
            if (modeNib) begin
              if (loHit || hiHit) begin
                colFlag_q <= 1'b1;
                colCode_q <= {hiHit ? memRdata[7:4] : colCode_q[7:4],
                              loHit ? memRdata[3:0] : colCode_q[3:0]};
              end
            end else if (byteHit && mode != `VBE_MODE_RSVD) begin
              colFlag_q <= 1'b1;
              colCode_q <= memRdata;
            end
          end
        end
        ST_DWR: begin
          if (!memReq) begin
            memWdata <= combined;
            memWe <= 1'b1;
            memReq <= 1'b1;
          end else if (memAck) begin
            memReq <= 1'b0;
            memWe <= 1'b0;
            state_q <= ST_BYTE;
          end
        end
        ST_BYTE: begin
          dstPtr_q <= dstPtr_q + dxStep;
          if (hzCnt_q != hZoom) begin
            // replicate the same source value horizontally
            hzCnt_q <= hzCnt_q + 3'h1;
            memAddr <= dstPtr_q + dxStep;
            state_q <= ST_DWR;
            if (mode != `VBE_MODE_COPY &&
                !(mode == `VBE_MODE_SET && colMask == 8'h00)) begin
              state_q <= ST_DRD;
              memReq <= 1'b1;
            end
            if (srcZero && mode != `VBE_MODE_COPY && mode != `VBE_MODE_AND &&
                mode != `VBE_MODE_RSVD) begin
              state_q <= ST_BYTE;
              memReq <= 1'b0;
            end
          end else begin
            hzCnt_q <= 3'h0;
            if (patEn && patCnt_q == patLen) begin
              srcPtr_q <= patBase_q;
              patCnt_q <= 6'h00;
            end else begin
              srcPtr_q <= srcPtr_q + sxStep;
              patCnt_q <= patCnt_q + 6'h01;
            end
            if (xCnt_q == width || stopReq_q) begin
              state_q <= ST_END;
            end else begin
              xCnt_q <= xCnt_q + 9'h001;
              state_q <= ST_SRC;
            end
          end
        end
        ST_END: begin
          dstLine_q <= dstLine_q + dyStep;
          if (vzCnt_q != vZoom && !stopReq_q) begin
            vzCnt_q <= vzCnt_q + 3'h1;
            state_q <= ST_LINE;
          end else if (yCnt_q != height && !stopReq_q) begin
            vzCnt_q <= 3'h0;
            yCnt_q <= yCnt_q + 8'h01;
            srcLine_q <= srcLine_q + syStep;
            state_q <= ST_LINE;
          end else if (chain && !stopReq_q) begin
            fetchIdx_q <= 5'h00;
            memAddr <= listPtr_q;
            memReq <= 1'b1;
            state_q <= ST_FETCH;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// *** vbe_blit_checker.sv ***
/* port checker for the blit engine: wishbone and video memory handshakes.
   assumes it is bound onto every engine instance and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module vbe_blit_checker #(
  parameter AW = 19
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // video memory
  input wire logic [AW-1:0] memAddr,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [7:0] memWdata,
  input wire logic memAck,
  // status
  input wire logic busy
);
  // --------
  // block fetch tracking
  // --------
  logic [4:0] fetchCnt_q;
  logic busy_q;
  wire logic [AW-1:0] addrInc = memAddr + 1'b1;
  // counts answered reads of the first block after each start
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fetchCnt_q <= 5'h15;
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy;
      if (busy && !busy_q)
        fetchCnt_q <= 5'h00;
      else if (memAck && fetchCnt_q < 5'h15)
        fetchCnt_q <= fetchCnt_q + 5'h01;
    end
  end
  // --------
  // properties
  // --------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence wbReq_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence startWr_s;
    wbReq_s ##0 (wb_we_i && wb_adr_i == 4'h8 && wb_sel_i[0] && wb_dat_i[0] && !busy);
  endsequence
  wb_ack_next_a: assert property (wbReq_s |=> wb_ack_o)
    else $error("wishbone ack not in the next cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("wishbone ack longer than one cycle");
  start_busy_a: assert property (startWr_s |-> ##[1:3] busy)
    else $error("start write did not make the engine busy");
  idle_quiet_a: assert property (!busy |-> !memReq)
    else $error("memory request while idle");
  req_held_a: assert property (memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWe))
    else $error("memory request changed before ack");
  wdata_held_a: assert property (memReq && memWe && !memAck |=> $stable(memWdata))
    else $error("write data changed before ack");
  fetch_next_a: assert property (memAck && fetchCnt_q < 5'h14 |=> memAddr == $past(addrInc))
    else $error("block bytes not fetched from consecutive addresses");
  fetch_read_a: assert property (memReq && fetchCnt_q < 5'h15 |-> !memWe)
    else $error("write during block fetch");
  start_c: cover property (startWr_s);
endmodule

bind vbe_blit_engine vbe_blit_checker #(.AW(AW)) chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .memAddr(memAddr), .memReq(memReq), .memWe(memWe),
  .memWdata(memWdata), .memAck(memAck), .busy(busy)
);
`default_nettype wire

// *** vbe_mem_model.sv ***
/* video memory model: byte array answering one request per ack pulse.
   assumes requests held until ack; lat sets the wait before each answer. */
`timescale 1ns/1ps
`default_nettype none
module vbe_mem_model #(
  parameter AW = 19
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // memory port
  input wire logic [AW-1:0] memAddr,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [7:0] memWdata,
  output logic memAck,
  output logic [7:0] memRdata,
  // answer delay in cycles
  input wire logic [3:0] lat
);
  logic [7:0] store [0:(1<<AW)-1];
  logic [7:0] rd_q;
  logic [3:0] wait_q;
  // outside the ack cycle the data lines show the inverse of the last value
  assign memRdata = memAck ? rd_q : ~rd_q;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      memAck <= 1'b0;
      wait_q <= 4'h0;
      rd_q <= 8'h00;
    end else if (memReq && !memAck && wait_q >= lat) begin
      memAck <= 1'b1;
      wait_q <= 4'h0;
      if (memWe)
        store[memAddr] <= memWdata;
      else
        rd_q <= store[memAddr];
    end else begin
      memAck <= 1'b0;
      if (memReq && !memAck)
        wait_q <= wait_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// *** vbe_tb.sv ***
/* bench for the blit engine: each list is also walked on a shadow memory
   and the result compared with the memory model. assumes model and checker. */
`timescale 1ns/1ps
`default_nettype none
`include "vbe_defines.vh"
module tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [3:0] wbAdr = 4'h0, wbSel = 4'h0, lat = 4'h0;
  logic [31:0] wbDat = 32'h0;
  wire logic [31:0] wbDatO;
  wire logic wbAck, memReq, memWe, memAck, busy;
  wire logic [18:0] memAddr;
  wire logic [7:0] memWdata, memRdata;
  logic [7:0] sh [0:524287];
  logic [7:0] refCode = 8'h00;
  logic refHit = 1'b0;
  int err_count = 0, tests_run = 0;
  vbe_blit_engine #(.AW(19)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .memAddr(memAddr), .memReq(memReq), .memWe(memWe),
    .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata), .busy(busy));
  vbe_mem_model #(.AW(19)) vram (.clk_sys(clk_sys), .rst_n(rst_n), .memAddr(memAddr),
    .memReq(memReq), .memWe(memWe), .memWdata(memWdata), .memAck(memAck),
    .memRdata(memRdata), .lat(lat));
  always #20 clk_sys = ~clk_sys;
  // --------
  // tasks
  // --------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [3:0] sel,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= sel;
    wbDat <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    q = wbDatO;
    check("wishbone ack", 32'h1, {31'h0, wbAck});
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task automatic put_blk(input logic [18:0] a, s, input logic [11:0] sy, input logic [7:0] sx,
      input logic [18:0] d, input logic [11:0] dy, input logic [7:0] dx, input logic [8:0] w,
      input logic [7:0] h, am, xm, cm, zm, pt, ct);
    logic [7:0] k [0:20];
    k = '{s[7:0], s[15:8], {5'h0, s[18:16]}, sy[7:0], {4'h0, sy[11:8]}, sx, d[7:0], d[15:8],
      {5'h0, d[18:16]}, dy[7:0], {4'h0, dy[11:8]}, dx, w[7:0], {7'h0, w[8]}, h, am, xm, cm,
      zm, pt, ct};
    for (int i = 0; i < 21; i++) begin
      sh[a + i] = k[i];
      vram.store[a + i] = k[i];
    end
  endtask
  task automatic ref_pix(input logic [7:0] s, input logic [18:0] d, input logic [2:0] m,
      input logic [7:0] cm);
    logic [7:0] dv;
    dv = sh[d];
    if (m == 3'h0 || m == 3'h7) begin
      sh[d] = s;
    end else if (m == 3'h6) begin
      if (s[3:0] != 4'h0 && dv[3:0] != 4'h0 && cm[dv[3:1]]) begin
        refCode[3:0] = dv[3:0];
        refHit = 1'b1;
      end
      if (s[7:4] != 4'h0 && dv[7:4] != 4'h0 && cm[dv[7:5]]) begin
        refCode[7:4] = dv[7:4];
        refHit = 1'b1;
      end
      sh[d] = {(s[7:4] != 4'h0) ? s[7:4] : dv[7:4], (s[3:0] != 4'h0) ? s[3:0] : dv[3:0]};
    end else begin
      if (s != 8'h00 && dv != 8'h00 && cm[dv[7:5]]) begin
        refCode = dv;
        refHit = 1'b1;
      end
      case (m)
        3'h1: sh[d] = (s != 8'h00) ? s : dv;
        3'h2: sh[d] = dv + s;
        3'h3: sh[d] = dv | s;
        3'h4: sh[d] = dv & s;
        default: sh[d] = dv ^ s;
      endcase
    end
  endtask
  task automatic ref_run(input logic [18:0] b);
    logic [7:0] k [0:20];
    logic [18:0] sl, dl, sp, dp;
    logic [7:0] s;
    logic more;
    int pc;
    more = 1'b1;
    while (more) begin
      for (int i = 0; i < 21; i++)
        k[i] = sh[b + i];
      b = b + 19'h15;
      sl = {k[2][2:0], k[1], k[0]};
      dl = {k[8][2:0], k[7], k[6]};
      for (int y = 0; y <= k[14]; y++) begin
        for (int j = 0; j <= k[18][6:4]; j++) begin
          sp = sl;
          dp = dl;
          pc = 0;
          for (int x = 0; x <= {k[13][0], k[12]}; x++) begin
            s = (sh[sp] & k[15]) ^ k[16];
            for (int i = 0; i <= k[18][2:0]; i++) begin
              ref_pix(s, dp, k[20][2:0], k[17]);
              dp = dp + {{11{k[11][7]}}, k[11]};
            end
            sp = sp + {{11{k[5][7]}}, k[5]};
            pc++;
            if (k[19][7] && pc == k[19][5:0] + 1) begin
              sp = sl;
              pc = 0;
            end
          end
          dl = dl + {{7{k[10][3]}}, k[10][3:0], k[9]};
        end
        sl = sl + {{7{k[4][3]}}, k[4][3:0], k[3]};
      end
      more = k[20][3];
    end
  endtask
  task automatic run_list(input logic [18:0] lp);
    logic [31:0] q;
    int n, bad;
    wb_xfer(1'b1, `VBE_REG_LIST_LO, 4'h3, {16'h0, lp[15:0]}, q);
    wb_xfer(1'b1, `VBE_REG_LIST_HI, 4'h1, {29'h0, lp[18:16]}, q);
    wb_xfer(1'b1, `VBE_REG_CTRL, 4'h1, 32'h1, q);
    n = 0;
    while (busy !== 1'b1 && n < 10) begin
      @(posedge clk_sys);
      n++;
    end
    while (busy !== 1'b0 && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    check("busy at end", 32'h0, {31'h0, busy});
    ref_run(lp);
    bad = 0;
    for (int a = 0; a < 524288; a++)
      if (vram.store[a] !== sh[a])
        bad++;
    check("differing memory bytes", 32'h0, bad);
    wb_xfer(1'b0, `VBE_REG_STAT, 4'hf, 32'h0, q);
    check("collision flag", {31'h0, refHit}, {31'h0, q[9]});
    if (refHit)
      check("collision code", {24'h0, refCode}, {24'h0, q[7:0]});
    refHit = 1'b0;
  endtask
  // --------
  // scenarios
  // --------
  task automatic sc_reset();
    logic [31:0] q;
    wb_xfer(1'b0, `VBE_REG_LIST_LO, 4'hf, 32'h0, q);
    check("list pointer", {13'h0, `VBE_ADDR_RST}, q);
    wb_xfer(1'b0, `VBE_REG_STAT, 4'hf, 32'h0, q);
    check("status", 32'h0, q);
    wb_xfer(1'b1, 4'h6, 4'hf, 32'hffffffff, q);
    wb_xfer(1'b0, 4'h6, 4'hf, 32'h0, q);
    check("unmapped read", 32'h0, q);
  endtask
  task automatic sc_copy();
    put_blk(19'h10000, 19'h01000, 12'h001, 8'hff, 19'h02000, 12'h001, 8'h80, 9'h004, 8'h02,
      8'h3c, 8'h00, 8'hff, 8'h00, 8'h00, 8'h08);
    put_blk(19'h10015, 19'h01100, 12'hff0, 8'h02, 19'h02100, 12'h020, 8'h01, 9'h005, 8'h01,
      8'hf3, 8'h5a, 8'hff, 8'h00, 8'h00, 8'h00);
    run_list(19'h10000);
  endtask
  task automatic sc_zoom();
    put_blk(19'h10100, 19'h04000, 12'h010, 8'h01, 19'h0a000, 12'h040, 8'h01, 9'h007, 8'h01,
      8'hff, 8'h00, 8'h00, 8'ha9, 8'h82, 8'h08);
    put_blk(19'h10115, 19'h04100, 12'h010, 8'h01, 19'h0a400, 12'h020, 8'h01, 9'h009, 8'h00,
      8'hff, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00);
    run_list(19'h10100);
  endtask
  task automatic sc_modes();
    logic [7:0] cmTab [1:7];
    cmTab = '{8'h00, 8'h81, 8'hff, 8'h42, 8'h18, 8'h55, 8'hff};
    lat <= 4'h2;
    for (int m = 1; m <= 7; m++)
      put_blk(19'h10200 + 19'h15 * (m - 1), 19'h05000 + 19'h40 * m, 12'h010, 8'h01,
        19'h0b000 + 19'h100 * m, 12'h010, 8'h01, 9'h00f, 8'h01, 8'hff, 8'h00, cmTab[m],
        8'h00, 8'h00, {4'h0, m < 7, 3'(m)});
    run_list(19'h10200);
    lat <= 4'h0;
  endtask
  task automatic sc_bounds();
    put_blk(19'h10400, 19'h7ff00, 12'h7ff, 8'h01, 19'h06000, 12'h800, 8'h01, 9'h1ff, 8'h01,
      8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08);
    put_blk(19'h10415, 19'h03000, 12'h001, 8'h01, 19'h09000, 12'hffe, 8'h01, 9'h000, 8'hff,
      8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    run_list(19'h10400);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 524288; i++) begin
      sh[i] = (i[2:0] == 3'h0) ? 8'h00 : (i[7:0] * 8'h0d) ^ i[15:8];
      vram.store[i] = sh[i];
    end
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    sc_reset();
    sc_copy();
    sc_zoom();
    sc_modes();
    sc_bounds();
    stop_test();
  end
  initial begin
    #4000000;
    err_count++;
    $display("mismatch watchdog expected %0d seen %0d", 0, 1);
    stop_test();
  end
endmodule
`default_nettype wire
